// file: logic/acf_pkg.sv
// Constants and types shared by the authenticated counter command front end
package acf_pkg;
	localparam logic [7:0] OP_AUTH_INPUT   = 8'h9B;
	localparam logic [7:0] OP_AUTH_OUTPUT  = 8'h96;
	localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
	localparam logic [7:0] OP_RESET        = 8'h99;
	localparam logic [7:0] TYPE_MASTER     = 8'h00;
	localparam logic [7:0] TYPE_KEY_UPDATE = 8'h01;
	localparam logic [7:0] TYPE_INCREMENT  = 8'h02;
	localparam logic [7:0] TYPE_REQUEST    = 8'h03;
	localparam logic [7:0] LEN_MASTER      = 8'd64;
	localparam logic [7:0] LEN_KEY_UPDATE  = 8'd40;
	localparam logic [7:0] LEN_INCREMENT   = 8'd40;
	localparam logic [7:0] LEN_REQUEST     = 8'd48;
	localparam logic [7:0] BYTE_TYPE       = 8'd1;
	localparam logic [7:0] BYTE_INDEX      = 8'd2;
	localparam logic [7:0] BYTE_WORD0      = 8'd4;
	localparam logic [7:0] BYTE_WORD3      = 8'd7;
	localparam logic [7:0] STATUS_RESET    = 8'h00;
	localparam int         ST_SUCCESS      = 7;
	localparam int         ST_FATAL        = 5;
	localparam int         ST_MISMATCH     = 4;
	localparam int         ST_KEY_UNINIT   = 3;
	localparam int         ST_SIG_ERR      = 2;
	localparam int         ST_MASTER_ERR   = 1;
	localparam int         ST_BUSY         = 0;
	localparam logic [1:0] NUM_COUNTERS    = 2'd3;
	localparam int         BITS_PER_BYTE   = 8;

	typedef enum logic [2:0] {
		ACF_IDLE = 3'b001,
		ACF_BUSY = 3'b010,
		ACF_DONE = 3'b100
	} acf_op_e;

	typedef struct packed {
		logic [1:0] status_code;
		logic       valid;
	} acf_dummy_s;
endpackage

// file: logic/acf_sync.sv
// Two-flop synchroniser for the serial pins
`timescale 1ns/1ns
`default_nettype none
module acf_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic d,
	input  wire logic rst_val,
	output logic      q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} acf_sync_s;
	acf_sync_s st_r;
	acf_sync_s st_nxt;

	always_comb begin
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	// Reset value is a constant per instance, driven from a tie at the parent
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= {rst_val, rst_val};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.s2;
endmodule
`default_nettype wire

// file: logic/acf_shift.sv
// Serial byte receiver and status transmitter on recovered clock edges
`timescale 1ns/1ns
`default_nettype none
module acf_shift
	import acf_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       sel,
	input  wire logic       sck_rise,
	input  wire logic       sck_fall,
	input  wire logic       din,
	input  wire logic [7:0] tx_byte,
	output logic [7:0]      rx_byte,
	output logic            rx_valid,
	output logic            dout
);
	typedef struct packed {
		logic [7:0] sh;
		logic [2:0] bitc;
		logic [7:0] rx;
		logic       rv;
		logic [7:0] tx;
		logic       out;
	} acf_shift_s;
	acf_shift_s st_r;
	acf_shift_s st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.rv = 1'b0;
		if (!sel) begin
			st_nxt.bitc = 3'd0;
			st_nxt.out  = 1'b0;
		end else begin
			if (sck_rise) begin
				st_nxt.sh   = {st_r.sh[6:0], din};
				st_nxt.bitc = st_r.bitc + 3'd1;
				if (st_r.bitc == 3'd7) begin
					st_nxt.rx = {st_r.sh[6:0], din};
					st_nxt.rv = 1'b1;
					st_nxt.tx = tx_byte;
				end
			end
			if (sck_fall) begin
				st_nxt.out = st_r.tx[7];
				st_nxt.tx  = {st_r.tx[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rx_byte  = st_r.rx;
	assign rx_valid = st_r.rv;
	assign dout     = st_r.out;
endmodule
`default_nettype wire

// file: logic/acf_top.sv
// Authenticated counter command front end: frame decode, status register, busy gating
// Function
// R1 - 9Bh command starts operation, busy held
// R2 - No suspend; only 66h then 99h aborts
// R3 - Flash commands run alongside authentication work
// R4 - New input command ignored while busy
// R5 - Status readable during operation; busy data invalid
// R6 - Reset sequence any time clears volatile state
// R7 - Eight-bit status with documented bit layout
// R8 - Status reads zero after power-up
// R9 - Clean completion of types 0-3 gives 80h
// R10 - Busy set during every type, cleared after
// R11 - Bit 1 master errors, length correct only
// R12 - Bit 2 signature, index, type, length errors
// R13 - Bit 3 key or counter uninitialised
// R14 - Bit 4 counter value mismatch, type 2
// R15 - Bit 5 fatal condition
// R16 - Status untouched before eight opcode bits
// R17 - Host frames opcode, type, index, reserved, payload
// R18 - Type 0 payload: master secret, shortened MAC
// R19 - Type 1 payload: key seed, signature
// R20 - Type 2 payload: counter value, signature
// R21 - Type 3 payload: nonce, signature
// R22 - Types 04h-FFh reported as type error
// R23 - Host sends reserved byte as zero
// R24 - Single-line serial, eight clocks per byte
// R25 - While busy repeat status from byte 3
// R26 - Host resets with 66h then 99h
// R27 - Early deselect gives wrong payload length
// R28 - Sample on rising edge, launch after deselect
`timescale 1ns/1ns
`default_nettype none
module acf_top
	import acf_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sck,
	input  wire logic        cs_n,
	input  wire logic        mosi,
	output logic             miso,
	output logic             miso_oe,
	output logic             op_start,
	output logic [7:0]       op_type,
	output logic [7:0]       op_index,
	output logic [31:0]      op_word,
	input  wire logic        op_done,
	input  wire logic        op_fatal,
	input  wire logic        op_sig_ok,
	input  wire logic        op_master_free,
	input  wire logic        op_key_init,
	input  wire logic        op_counter_init,
	input  wire logic        op_value_match,
	output logic             op_abort,
	output logic [7:0]       auth_command_status
);
	typedef struct packed {
		acf_op_e    op;
		logic [7:0] status;
		logic [7:0] opcode;
		logic [7:0] nbytes;
		logic [7:0] ctype;
		logic [7:0] index;
		logic [31:0] word;
		logic       in_cmd;
		logic       out_cmd;
		logic       len_bad;
		logic       rst_armed;
		logic       sel_d;
		logic       sck_d;
		logic       start;
		logic       abort;
	} acf_top_s;
	acf_top_s st_r;
	acf_top_s st_nxt;

	logic       sck_s;
	logic       cs_n_s;
	logic       mosi_s;
	logic       sel;
	logic       sck_rise;
	logic       sck_fall;
	logic [7:0] rx_byte;
	logic       rx_valid;
	logic       shift_out;
	logic [7:0] tx_byte;

	// Expected frame length for a command type; zero marks a reserved type
	function automatic logic [7:0] frame_len(input logic [7:0] t);
		case (t)
			TYPE_MASTER:     frame_len = LEN_MASTER;
			TYPE_KEY_UPDATE: frame_len = LEN_KEY_UPDATE;
			TYPE_INCREMENT:  frame_len = LEN_INCREMENT;
			TYPE_REQUEST:    frame_len = LEN_REQUEST;
			default:         frame_len = 8'd0;
		endcase
	endfunction

	// Pins come from the host clock domain, so each passes two flops
	acf_sync u_sck (.clk(clk), .rst(rst), .d(sck), .rst_val(1'b0), .q(sck_s));
	acf_sync u_cs (.clk(clk), .rst(rst), .d(cs_n), .rst_val(1'b1), .q(cs_n_s));
	acf_sync u_mosi (.clk(clk), .rst(rst), .d(mosi), .rst_val(1'b0), .q(mosi_s));

	assign sel      = ~cs_n_s;
	assign sck_rise = sel & sck_s & ~st_r.sck_d; // R28
	assign sck_fall = sel & ~sck_s & st_r.sck_d;

	// Byte 0 is the opcode, then status goes out from byte 1 and repeats in every later byte
	assign tx_byte = st_r.status; // R25 R5

	acf_shift u_shift (
		.clk      (clk),
		.rst      (rst),
		.sel      (sel),
		.sck_rise (sck_rise),
		.sck_fall (sck_fall),
		.din      (mosi_s),
		.tx_byte  (tx_byte),
		.rx_byte  (rx_byte),
		.rx_valid (rx_valid),
		.dout     (shift_out)
	); // R24

	always_comb begin
		logic [7:0] st;
		logic [7:0] need;
		st              = st_r.status;
		need            = frame_len(st_r.ctype);
		st_nxt          = st_r;
		st_nxt.start    = 1'b0;
		st_nxt.abort    = 1'b0;
		st_nxt.sel_d    = sel;
		st_nxt.sck_d    = sck_s;

		if (rx_valid) begin
			st_nxt.nbytes = st_r.nbytes + 8'd1;
			if (st_r.nbytes == 8'd0) begin
				st_nxt.opcode = rx_byte;
				// A 9Bh seen while an operation runs never opens a frame
				if (rx_byte == OP_AUTH_INPUT && st_r.op == ACF_IDLE) begin
					st_nxt.in_cmd = 1'b1; // R4
				end
				st_nxt.out_cmd = (rx_byte == OP_AUTH_OUTPUT);
			end
			if (st_r.in_cmd) begin
				if (st_r.nbytes == BYTE_TYPE) begin
					st_nxt.ctype = rx_byte;
				end
				if (st_r.nbytes == BYTE_INDEX) begin
					st_nxt.index = rx_byte;
				end
				if (st_r.nbytes >= BYTE_WORD0 && st_r.nbytes <= BYTE_WORD3) begin
					st_nxt.word = {st_r.word[23:0], rx_byte}; // R19 R20
				end
			end
		end

		// Deselect ends a frame; launch or arm reset only now
		if (st_r.sel_d && !sel) begin
			st_nxt.nbytes  = 8'd0;
			st_nxt.in_cmd  = 1'b0;
			st_nxt.out_cmd = 1'b0;
			// Any other frame after 66h disarms, so a stray byte cannot abort
			if (st_r.nbytes == 8'd1 && st_r.opcode == OP_RESET_ENABLE) begin
				st_nxt.rst_armed = 1'b1;
			end else if (st_r.nbytes == 8'd1 && st_r.opcode == OP_RESET && st_r.rst_armed) begin
				st_nxt.rst_armed = 1'b0;
				st_nxt.abort     = 1'b1;
				st_nxt.op        = ACF_IDLE; // R2 R6
				st_nxt.status    = STATUS_RESET;
				st_nxt.ctype     = 8'h00;
				st_nxt.index     = 8'h00;
				st_nxt.word      = 32'h0000_0000;
			end else begin
				st_nxt.rst_armed = 1'b0;
			end
			// Frames too short for type byte leave status alone
			if (st_r.in_cmd && st_r.nbytes > BYTE_TYPE) begin // R16
				st_nxt.len_bad = (need == 8'd0) || (st_r.nbytes != need); // R27 R22
				st_nxt.op      = ACF_BUSY; // R1
				st_nxt.start   = 1'b1;
				st_nxt.status  = 8'h01; // R10
			end
		end

		case (st_r.op)
			ACF_IDLE: begin
			end
			ACF_BUSY: begin
				// A reserved type or bad length ends at once with bit 2
				if (st_r.len_bad) begin
					st                  = 8'h00;
					st[ST_SIG_ERR]      = 1'b1; // R12 R22
					st_nxt.status       = st;
					st_nxt.op           = ACF_DONE;
				end else if (op_done) begin
					st = 8'h00;
					if (op_fatal) begin
						st[ST_FATAL] = 1'b1; // R15
					end else if (st_r.ctype == TYPE_MASTER) begin
						st[ST_MASTER_ERR] = !op_master_free || st_r.index > {6'd0, NUM_COUNTERS} || !op_sig_ok; // R11
					end else if (st_r.ctype == TYPE_KEY_UPDATE) begin
						st[ST_MASTER_ERR] = !op_counter_init; // R11
						st[ST_SIG_ERR]    = !op_sig_ok || st_r.index > {6'd0, NUM_COUNTERS}; // R12
					end else begin
						st[ST_KEY_UNINIT] = !op_key_init || !op_counter_init; // R13
						st[ST_SIG_ERR]    = !op_sig_ok || st_r.index > {6'd0, NUM_COUNTERS}; // R12
						if (st_r.ctype == TYPE_INCREMENT) begin
							st[ST_MISMATCH] = !op_value_match; // R14
						end
					end
					st[ST_SUCCESS] = (st[6:0] == 7'd0); // R9
					st_nxt.status  = st; // R7
					st_nxt.op      = ACF_DONE;
				end
			end
			ACF_DONE: begin
				st_nxt.op = ACF_IDLE;
			end
			default: begin
				st_nxt.op = ACF_IDLE;
			end
		endcase
		// Abort wins over any completion in the same cycle
		if (st_nxt.abort) begin
			st_nxt.op     = ACF_IDLE;
			st_nxt.status = STATUS_RESET;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r        <= '0;
			st_r.op     <= ACF_IDLE;
			st_r.status <= STATUS_RESET; // R8
		end else begin
			st_r <= st_nxt;
		end
	end

	// Only this unit's own commands are seen; flash array path is separate
	assign miso                = shift_out; // R3
	assign miso_oe             = sel & st_r.out_cmd;
	// Length and type errors are settled here, so the engine never starts on them
	assign op_start            = st_r.start & ~st_r.len_bad;
	assign op_type             = st_r.ctype;
	assign op_index            = st_r.index;
	assign op_word             = st_r.word;
	assign op_abort            = st_r.abort;
	assign auth_command_status = st_r.status;

	a_busy_while_op: assert property (@(posedge clk) disable iff (rst)
		(st_r.op == ACF_BUSY) |-> auth_command_status[ST_BUSY]) // R1
		else $error("busy low during operation");
	a_status_reset: assert property (@(posedge clk) disable iff (rst)
		op_abort |-> auth_command_status == STATUS_RESET) // R6
		else $error("reset did not clear status");
	a_no_restart: assert property (@(posedge clk) disable iff (rst)
		(st_r.op == ACF_BUSY) |=> !(st_r.start)) // R4
		else $error("new command taken while busy");
	a_success_only: assert property (@(posedge clk) disable iff (rst)
		auth_command_status[ST_SUCCESS] |-> auth_command_status[6:0] == 7'd0) // R9
		else $error("success with other bits");
	a_busy_clears: assert property (@(posedge clk) disable iff (rst)
		(st_r.op == ACF_DONE) |-> !auth_command_status[ST_BUSY]) // R10
		else $error("busy still set after completion");
	a_len_error: assert property (@(posedge clk) disable iff (rst)
		(st_r.op == ACF_BUSY && st_r.len_bad) |=> auth_command_status == 8'h04 || op_abort) // R12
		else $error("length error not reported");
	a_launch_deselect: assert property (@(posedge clk) disable iff (rst)
		$rose(st_r.start) |-> $past(st_r.sel_d) && !st_r.sel_d) // R28
		else $error("launch without deselect");
	a_status_stable: assert property (@(posedge clk) disable iff (rst)
		(st_r.op == ACF_IDLE && !st_r.abort && !st_r.start) |=> $stable(auth_command_status) || st_r.start || op_abort) // R16
		else $error("status moved while idle");
	c_success: cover property (@(posedge clk) auth_command_status == 8'h80);
	c_abort: cover property (@(posedge clk) (st_r.op == ACF_BUSY) ##1 op_abort);
	c_len_bad: cover property (@(posedge clk) auth_command_status == 8'h04);

	// Gating and completion checks; an abort may cut any of these short
	a_ignore_busy: assert property (@(posedge clk) disable iff (rst)
		(st_r.op == ACF_BUSY && rx_valid && st_r.nbytes == 8'd0) |=> !st_r.in_cmd) // R4
		else $error("input command opened while busy");
	a_busy_until_done: assert property (@(posedge clk) disable iff (rst)
		(st_r.op == ACF_BUSY && !st_r.len_bad && !op_done) |=> auth_command_status[ST_BUSY] || op_abort) // R1
		else $error("busy dropped before completion");
	a_done_clears_busy: assert property (@(posedge clk) disable iff (rst)
		(st_r.op == ACF_BUSY && !st_r.len_bad && op_done) |=> !auth_command_status[ST_BUSY]) // R10
		else $error("busy kept after completion");
	a_status_layout: assert property (@(posedge clk) disable iff (rst)
		!auth_command_status[6]) // R7
		else $error("undefined status bit set");
	a_reserved_refused: assert property (@(posedge clk) disable iff (rst)
		(st_r.start && frame_len(st_r.ctype) == 8'd0) |-> !op_start) // R22
		else $error("reserved type launched");
	a_abort_after_pair: assert property (@(posedge clk) disable iff (rst)
		op_abort |-> $past(st_r.opcode) == OP_RESET && $past(st_r.rst_armed)) // R2
		else $error("abort without reset pair");
	// Ignored input command and key error are the paths most easily missed
	c_ignored: cover property (@(posedge clk) st_r.op == ACF_BUSY && rx_valid && st_r.nbytes == 8'd0);
	c_key_uninit: cover property (@(posedge clk) auth_command_status == 8'h08);
endmodule
`default_nettype wire

// file: testbench/acf_host_model.sv
// Host controller model sending authenticated command frames
`timescale 1ns/1ns
`default_nettype none
module acf_host_model
	import acf_pkg::*;
(
	output logic      sck,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso
);
	localparam int HALF = 40;
	initial begin
		sck  = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	task automatic sel();
		#(HALF) cs_n = 1'b0;
		#(HALF);
	endtask
	// Released data line flips so a stale bit is never mistaken for data
	task automatic desel();
		#(HALF) cs_n = 1'b1;
		mosi = ~mosi;
		#(HALF * 2);
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			#(HALF) sck = 1'b1;
			rx[i] = miso;
			#(HALF) sck = 1'b0;
		end
	endtask
	task automatic frame(input logic [7:0] t, input logic [7:0] idx, input logic [31:0] w, input int n);
		logic [7:0] b;
		logic [7:0] rx;
		sel();
		for (int i = 0; i < n; i++) begin
			b = (i == 0) ? OP_AUTH_INPUT : (i == 1) ? t : (i == 2) ? idx : (i == 3) ? 8'h00 :
				(i < 8) ? w[8 * (7 - i) +: 8] : 8'(i * 37);
			xfer(b, rx);
		end
		desel();
	endtask
	task automatic single(input logic [7:0] op);
		logic [7:0] rx;
		sel();
		xfer(op, rx);
		desel();
	endtask
	task automatic read_status(output logic [7:0] s1, output logic [7:0] s3);
		logic [7:0] rx;
		sel();
		xfer(OP_AUTH_OUTPUT, rx);
		xfer(8'h00, rx);
		xfer(8'h00, s1);
		xfer(8'h00, s3);
		desel();
	endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the authenticated counter command front end
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import acf_pkg::*;
	logic        clk, rst, sck, cs_n, mosi, miso, miso_oe, op_start, op_done, op_abort;
	logic        op_fatal, op_sig_ok, op_master_free, op_key_init, op_counter_init, op_value_match;
	logic [7:0]  op_type, op_index, auth_command_status, s1, s3;
	logic [31:0] op_word;
	logic [15:0] lfsr;
	int          n_fail = 0, cmp_count = 0, n_start = 0, n_abort = 0, n_oe = 0;
	logic [7:0]  tt [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h01, 8'h01, 8'h02, 8'h03, 8'h02};
	logic [5:0]  tf [10] = '{6'h1F, 6'h1F, 6'h1F, 6'h1F, 6'h17, 6'h1D, 6'h0F, 6'h1E, 6'h1B, 6'h3F};
	logic [7:0]  te [10] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h02, 8'h02, 8'h04, 8'h10, 8'h08, 8'h20};
	acf_top u_acf_top (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
		.miso_oe(miso_oe), .op_start(op_start), .op_type(op_type), .op_index(op_index), .op_word(op_word),
		.op_done(op_done), .op_fatal(op_fatal), .op_sig_ok(op_sig_ok), .op_master_free(op_master_free),
		.op_key_init(op_key_init), .op_counter_init(op_counter_init), .op_value_match(op_value_match),
		.op_abort(op_abort), .auth_command_status(auth_command_status));
	acf_host_model u_acf_host_model (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (op_start === 1'b1) n_start++;
		if (op_abort === 1'b1) n_abort++;
		if (miso_oe === 1'b1) n_oe++;
	end
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		for (int i = 0; i < 16; i++) v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
		return v;
	endfunction
	function automatic int len_of(input logic [7:0] t);
		case (t)
			TYPE_MASTER:     return int'(LEN_MASTER);
			TYPE_KEY_UPDATE: return int'(LEN_KEY_UPDATE);
			TYPE_INCREMENT:  return int'(LEN_INCREMENT);
			TYPE_REQUEST:    return int'(LEN_REQUEST);
			default:         return 40;
		endcase
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Bounded wait for a pulse counter to move
	task automatic wait_cnt(ref int c, input int was, input string what);
		for (int k = 0; k < 100 && c == was; k++) @(negedge clk);
		if (c == was) begin
			n_fail++;
			$display("ERROR %s expected pulse seen none", what);
			give_verdict();
		end
	endtask
	task automatic finish_op(input logic [5:0] fl);
		repeat (5) @(negedge clk);
		{op_fatal, op_sig_ok, op_master_free, op_key_init, op_counter_init, op_value_match} = fl;
		op_done = 1'b1;
		@(negedge clk);
		op_done = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic run_cmd(input logic [7:0] t, input logic [5:0] fl, input logic [7:0] exp, input bit extra);
		logic [31:0] w;
		logic [7:0]  idx;
		int          was;
		lfsr = lfsr_next(lfsr);
		w = {lfsr, lfsr_next(lfsr)};
		idx = {6'h00, lfsr[1:0]};
		was = n_start;
		u_acf_host_model.frame(t, idx, w, len_of(t));
		wait_cnt(n_start, was, "op_start");
		check("op_type", op_type, t);
		check("op_index", op_index, idx);
		check("op_word", op_word, w);
		@(negedge clk);
		check("busy", auth_command_status, 8'h01);
		if (extra) begin
			u_acf_host_model.read_status(s1, s3);
			check("link status", s1, 8'h01);
			check("repeated status", s3, 8'h01);
			u_acf_host_model.frame(TYPE_REQUEST, idx, ~w, len_of(TYPE_REQUEST));
			repeat (10) @(negedge clk);
			check("starts", n_start, was + 1);
			check("busy kept", auth_command_status, 8'h01);
		end
		finish_op(fl);
		check("final status", auth_command_status, exp);
		$display("test command %0h done", t);
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		$display("ERROR watchdog expected finish seen hang");
		give_verdict();
	end
	initial begin
		logic [7:0] t;
		int         was;
		rst = 1'b1;
		op_done = 1'b0;
		{op_fatal, op_sig_ok, op_master_free, op_key_init, op_counter_init, op_value_match} = 6'h00;
		lfsr = 16'd41176;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		u_acf_host_model.read_status(s1, s3);
		check("power-up status", auth_command_status, STATUS_RESET);
		check("power-up link", s1, STATUS_RESET);
		check("oe on read", n_oe > 0, 1'b1);
		for (int i = 0; i < 10; i++) run_cmd(tt[i], tf[i], te[i], i == 2);
		u_acf_host_model.single(OP_AUTH_INPUT);
		repeat (10) @(negedge clk);
		check("opcode only", auth_command_status, 8'h20);
		was = n_oe;
		u_acf_host_model.frame(TYPE_INCREMENT, 8'h01, 32'h0, len_of(TYPE_INCREMENT) - 1);
		repeat (10) @(negedge clk);
		check("short frame", auth_command_status, 8'h04);
		check("oe on input", n_oe, was);
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_next(lfsr);
			t = (i == 0) ? 8'h04 : (i == 1) ? 8'hFF : 8'h04 + 8'(lfsr % 252);
			was = n_start;
			u_acf_host_model.frame(t, 8'h00, 32'h0, 40);
			repeat (10) @(negedge clk);
			check("reserved type", auth_command_status, 8'h04);
			check("no launch", n_start, was);
		end
		was = n_start;
		u_acf_host_model.frame(TYPE_INCREMENT, 8'h04, {lfsr, lfsr}, len_of(TYPE_INCREMENT));
		wait_cnt(n_start, was, "op_start");
		finish_op(6'h1F);
		check("index range", auth_command_status, 8'h04);
		was = n_start;
		u_acf_host_model.frame(TYPE_MASTER, 8'hFF, {lfsr, lfsr}, len_of(TYPE_MASTER));
		wait_cnt(n_start, was, "op_start");
		finish_op(6'h1F);
		check("master index", auth_command_status, 8'h02);
		$display("test errors done");
		was = n_start;
		u_acf_host_model.frame(TYPE_REQUEST, 8'h02, {lfsr, lfsr}, len_of(TYPE_REQUEST));
		wait_cnt(n_start, was, "op_start");
		u_acf_host_model.single(OP_RESET_ENABLE);
		check("no abort yet", n_abort, 0);
		check("still busy", auth_command_status, 8'h01);
		was = n_abort;
		u_acf_host_model.single(OP_RESET);
		wait_cnt(n_abort, was, "op_abort");
		@(negedge clk);
		check("aborted status", auth_command_status, STATUS_RESET);
		finish_op(6'h1F);
		check("late done", auth_command_status, STATUS_RESET);
		run_cmd(TYPE_INCREMENT, 6'h1F, 8'h80, 1'b0);
		$display("test abort done");
		give_verdict();
	end
endmodule
`default_nettype wire
